// ### verilog/bgm_top.sv
// Purpose: Bandgap drift supervision and OV/UV comparator self-test
// Assumes: reg_secure marks a write that passed the secure sequence
// Notes:   Register port fed from a protected I2C layer
// Contract
// RQ1 - 4 to 12 percent bandgap mismatch is critical
// RQ2 - Mismatch keeps switching regulators from powering up
// RQ3 - Bandgap error at power-up fails, bypass ignored
// RQ4 - Drift when on, bypass 0: shut regulators
// RQ5 - Drift when on, bypass 1: interrupt only
// RQ6 - Bandgap fault flag sets unless masked
// RQ7 - Live status bit follows bandgap condition
// RQ8 - Power-up test toggles every OV/UV comparator
// RQ9 - Failing comparator sets its per-rail warn bit
// RQ10 - Each test run overwrites all warn registers
// RQ11 - Warn clears need secure write when enabled
// RQ12 - Power-up continues whatever the test result
// RQ13 - Writing trigger 1 starts on-demand test
// RQ14 - Trigger self-clears when the test ends
// RQ15 - Host sets trigger by secure write
// RQ16 - On-demand blanking lasts at most 200 us
// RQ17 - Host requests test only when safe
// RQ18 - On-demand failures set warn bits
// RQ19 - Host reads warn bits after each test
// RQ20 - Trigger write ignored while test runs
`timescale 1ns/100ps
module bgm_top #(
	parameter int BLANK_MAX_CYC = `BGM_BLANK_MAX_CYC,
	parameter int SETTLE_CYC = `BGM_SETTLE_CYC
) (
	input wire logic clk_sys,
	input wire logic rst,
	input wire bgm_pkg::bgm_byte_t reg_addr,
	input wire bgm_pkg::bgm_byte_t reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	input wire logic reg_secure,
	output bgm_pkg::bgm_byte_t reg_rdata,
	input wire bgm_pkg::bgm_pct_t bg_diff_pct,
	input wire logic pwrup_req,
	input wire logic pwrdn_req,
	input wire bgm_pkg::bgm_cmp_vec_t cmp_out,
	output logic cmp_test_stim,
	output logic monitor_blank,
	output logic reg_power_en,
	output logic pwrup_blocked,
	output logic bandgap_irq
);
	import bgm_pkg::*;

	// ------------------------------------------------------------------
	// Declarations
	// ------------------------------------------------------------------
	bgm_st_if st (); // Link to the self-test engine
	logic bg_fault; // Live bandgap drift
	logic bg_fault_rise; // Drift onset pulse
	bgm_pwr_state_t pwr, next_pwr; // Power control state
	logic bg_seen, next_bg_seen; // Drift seen during power-up test
	logic od_run, next_od_run; // On-demand run in progress
	logic trigger, next_trigger; // selftest_on_demand_trigger
	logic bypass, next_bypass; // bandgap_drift_bypass_cfg
	logic sec_en, next_sec_en; // Secure writing enabled
	logic irq_mask, next_irq_mask; // Bandgap interrupt masked
	logic irq_flag, next_irq_flag; // bandgap_fault_irq_flag
	bgm_cmp_vec_t warn, next_warn; // All self-test warn bits
	bgm_byte_t next_rdata; // Read data for next cycle
	logic wr_ok; // Write allowed under secure mode
	logic pwr_start; // Power-up test request
	logic od_start; // On-demand test request
	logic [15:0] blank_cnt, next_blank_cnt; // Blanking length

	// Address hit of a strobe
	function automatic logic hit(input logic strobe, input bgm_byte_t a,
		input bgm_byte_t off);
		return strobe && (a == off);
	endfunction

	// ------------------------------------------------------------------
	// Submodules
	// ------------------------------------------------------------------
	// Bandgap comparison
	bgm_bg_mon u_bg (
		.clk_sys(clk_sys),
		.rst(rst),
		.bg_diff_pct(bg_diff_pct),
		.bg_fault(bg_fault),
		.bg_fault_rise(bg_fault_rise)
	);

	// Comparator self-test engine
	bgm_selftest #(.SETTLE_CYC(SETTLE_CYC)) u_st (
		.clk_sys(clk_sys),
		.rst(rst),
		.st(st.eng),
		.cmp_out(cmp_out),
		.cmp_test_stim(cmp_test_stim)
	);

	// ------------------------------------------------------------------
	// Power control
	// ------------------------------------------------------------------
	// Power-up and on-demand starts never collide; power-up wins
	assign pwr_start = (pwr == PWR_OFF) && pwrup_req && !bg_fault &&
		!st.busy && !od_run;
	assign od_start = trigger && !od_run && !st.busy && !pwr_start;
	assign st.start = pwr_start | od_start;
	// RQ16 blanking during any run
	assign monitor_blank = st.busy;
	assign reg_power_en = (pwr == PWR_ON);
	assign pwrup_blocked = (pwr == PWR_BLOCKED);
	assign bandgap_irq = irq_flag;

	// Next power state
	always_comb begin
		next_pwr = pwr;
		next_bg_seen = bg_seen;
		case (pwr)
			PWR_OFF: begin
				next_bg_seen = 1'b0;
				// RQ2 drift blocks power-up
				if (pwrup_req && bg_fault) begin
					next_pwr = PWR_BLOCKED;
				end else if (pwr_start) begin
					next_pwr = PWR_TEST;
				end
			end
			PWR_TEST: begin
				// RQ3 drift fails power-up test
				next_bg_seen = bg_seen | bg_fault;
				if (st.done) begin
					// RQ12 continue after comparator test
					next_pwr = (bg_seen | bg_fault) ? PWR_BLOCKED : PWR_ON;
				end
			end
			PWR_ON: begin
				if (pwrdn_req) begin
					next_pwr = PWR_OFF;
				// RQ4 shutdown unless bypassed
				end else if (bg_fault && !bypass) begin
					next_pwr = PWR_OFF;
				end
			end
			PWR_BLOCKED: begin
				// Held until the request drops
				if (!pwrup_req) begin
					next_pwr = PWR_OFF;
				end
			end
			default: next_pwr = PWR_OFF;
		endcase
	end

	// Register power state
	always_ff @(posedge clk_sys) begin
		if (rst) begin
			pwr <= PWR_OFF;
			bg_seen <= 1'b0;
		end else begin
			pwr <= next_pwr;
			bg_seen <= next_bg_seen;
		end
	end
	// ------------------------------------------------------------------
	// Registers
	// ------------------------------------------------------------------
	// Protected writes need reg_secure while secure mode is on
	assign wr_ok = reg_wr && (!sec_en || reg_secure);
	// Next register values; hardware sets win over host clears
	always_comb begin
		next_bypass = bypass;
		next_sec_en = sec_en;
		next_irq_mask = irq_mask;
		next_trigger = trigger;
		next_od_run = od_run;
		next_irq_flag = irq_flag;
		next_warn = warn;
		next_blank_cnt = st.busy ? blank_cnt + 16'h0001 : 16'h0000;
		if (hit(wr_ok, reg_addr, `BGM_OFF_CTRL)) begin
			next_bypass = reg_wdata[`BGM_CTRL_BYP_BIT];
			next_sec_en = reg_wdata[`BGM_CTRL_SEC_BIT];
			// RQ20 ignore trigger while busy
			if (!st.busy && !od_run) begin
				// RQ13 RQ15 trigger on write of one
				next_trigger = trigger | reg_wdata[`BGM_CTRL_TRIG_BIT];
			end
		end
		if (hit(reg_wr, reg_addr, `BGM_OFF_MASK)) begin
			next_irq_mask = reg_wdata[0];
		end
		// Flag cleared by writing one
		if (hit(reg_wr, reg_addr, `BGM_OFF_IRQ) && reg_wdata[0]) begin
			next_irq_flag = 1'b0;
		end
		// RQ5 RQ6 interrupt on drift onset
		if (bg_fault_rise && !irq_mask) begin
			next_irq_flag = 1'b1;
		end
		// RQ11 warn bits cleared by writing one
		if (hit(wr_ok, reg_addr, `BGM_OFF_BUCK_OV)) begin
			next_warn[`BGM_LIN_OV_LSB-1:`BGM_BUCK_OV_LSB] &=
				~reg_wdata[`BGM_N_BUCK-1:0];
		end
		if (hit(wr_ok, reg_addr, `BGM_OFF_LIN_OV)) begin
			next_warn[`BGM_BUCK_UV_LSB-1:`BGM_LIN_OV_LSB] &=
				~reg_wdata[`BGM_N_LIN-1:0];
		end
		if (hit(wr_ok, reg_addr, `BGM_OFF_BUCK_UV)) begin
			next_warn[`BGM_LIN_UV_LSB-1:`BGM_BUCK_UV_LSB] &=
				~reg_wdata[`BGM_N_BUCK-1:0];
		end
		if (hit(wr_ok, reg_addr, `BGM_OFF_LIN_UV)) begin
			next_warn[`BGM_N_CMP-1:`BGM_LIN_UV_LSB] &=
				~reg_wdata[`BGM_N_LIN-1:0];
		end
		if (od_start) begin
			next_od_run = 1'b1;
		end
		if (st.done) begin
			// RQ10 RQ18 overwrite with latest result
			next_warn = st.fail;
			// RQ14 trigger self-clears
			if (od_run) begin
				next_trigger = 1'b0;
				next_od_run = 1'b0;
			end
		end
	end
	// Read mux; unmapped offsets read zero
	always_comb begin
		next_rdata = `BGM_RDATA_RST;
		if (reg_rd) begin
			case (reg_addr)
				`BGM_OFF_STATUS: begin
					// RQ7 live drift status
					next_rdata[`BGM_STAT_BG_BIT] = bg_fault;
					next_rdata[`BGM_STAT_BUSY_BIT] = st.busy;
					next_rdata[`BGM_STAT_ON_BIT] = (pwr == PWR_ON);
					next_rdata[`BGM_STAT_BLK_BIT] = (pwr == PWR_BLOCKED);
				end
				`BGM_OFF_IRQ: next_rdata[0] = irq_flag;
				`BGM_OFF_MASK: next_rdata[0] = irq_mask;
				`BGM_OFF_CTRL: begin
					next_rdata[`BGM_CTRL_TRIG_BIT] = trigger;
					next_rdata[`BGM_CTRL_BYP_BIT] = bypass;
					next_rdata[`BGM_CTRL_SEC_BIT] = sec_en;
				end
				`BGM_OFF_BUCK_OV: next_rdata = {1'b0,
					warn[`BGM_LIN_OV_LSB-1:`BGM_BUCK_OV_LSB]};
				`BGM_OFF_LIN_OV: next_rdata = {4'h0,
					warn[`BGM_BUCK_UV_LSB-1:`BGM_LIN_OV_LSB]};
				`BGM_OFF_BUCK_UV: next_rdata = {1'b0,
					warn[`BGM_LIN_UV_LSB-1:`BGM_BUCK_UV_LSB]};
				`BGM_OFF_LIN_UV: next_rdata = {4'h0,
					warn[`BGM_N_CMP-1:`BGM_LIN_UV_LSB]};
				default: next_rdata = `BGM_RDATA_RST;
			endcase
		end
	end

	// Register the register file
	always_ff @(posedge clk_sys) begin
		if (rst) begin
			bypass <= 1'(`BGM_CTRL_RST >> `BGM_CTRL_BYP_BIT);
			sec_en <= 1'(`BGM_CTRL_RST >> `BGM_CTRL_SEC_BIT);
			trigger <= 1'(`BGM_CTRL_RST >> `BGM_CTRL_TRIG_BIT);
			irq_mask <= `BGM_MASK_RST;
			irq_flag <= 1'b0;
			od_run <= 1'b0;
			warn <= '0;
			reg_rdata <= `BGM_RDATA_RST;
			blank_cnt <= 16'h0000;
		end else begin
			bypass <= next_bypass;
			sec_en <= next_sec_en;
			trigger <= next_trigger;
			irq_mask <= next_irq_mask;
			irq_flag <= next_irq_flag;
			od_run <= next_od_run;
			warn <= next_warn;
			reg_rdata <= next_rdata;
			blank_cnt <= next_blank_cnt;
		end
	end
	// ------------------------------------------------------------------
	// Checks
	// ------------------------------------------------------------------
	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (rst);
	// Accepted trigger write
	sequence trig_write_s;
		hit(wr_ok, reg_addr, `BGM_OFF_CTRL) &&
			reg_wdata[`BGM_CTRL_TRIG_BIT] && !st.busy && !od_run &&
			!trigger;
	endsequence
	// Trigger set, then engine busy
	sequence trig_run_s;
		trigger ##1 (st.busy && od_run);
	endsequence
	block_up_a: assert property ( // RQ2
		pwr == PWR_OFF && pwrup_req && bg_fault |=> pwr == PWR_BLOCKED)
		else $error("power-up not blocked on drift");
	test_fail_a: assert property ( // RQ3
		pwr == PWR_TEST && st.done && bg_fault |=> pwrup_blocked)
		else $error("bandgap error did not fail power-up");
	drift_shut_a: assert property ( // RQ4
		reg_power_en && bg_fault && !bypass |=> !reg_power_en)
		else $error("drift did not shut regulators");
	bypass_keep_a: assert property ( // RQ5
		reg_power_en && bg_fault && bypass && !pwrdn_req |=> reg_power_en)
		else $error("bypassed drift stopped regulators");
	irq_set_a: assert property ( // RQ6
		bg_fault_rise && !irq_mask |=> bandgap_irq)
		else $error("bandgap flag not set");
	live_stat_a: assert property ( // RQ7
		hit(reg_rd, reg_addr, `BGM_OFF_STATUS) |=>
		reg_rdata[`BGM_STAT_BG_BIT] == $past(bg_fault))
		else $error("status bit does not follow drift");
	warn_load_a: assert property ( // RQ10
		st.done |=> warn == $past(st.fail))
		else $error("warn bits not overwritten by run");
	warn_guard_a: assert property ( // RQ11
		sec_en && reg_wr && !reg_secure && !st.done |=> $stable(warn))
		else $error("plain write changed warn bits");
	pwr_cont_a: assert property ( // RQ12
		pwr == PWR_TEST && st.done && !bg_fault && !bg_seen |=>
		reg_power_en)
		else $error("power-up did not continue after test");
	trig_start_a: assert property ( // RQ13
		trig_write_s |=> trig_run_s)
		else $error("trigger did not start a test");
	trig_clear_a: assert property ( // RQ14
		st.done && od_run |=> !trigger && !od_run)
		else $error("trigger did not self-clear");
	blank_max_a: assert property ( // RQ16
		blank_cnt <= 16'(BLANK_MAX_CYC))
		else $error("monitor blanking too long");
	busy_ignore_a: assert property ( // RQ20
		od_run && !st.done |=> od_run && trigger)
		else $error("running on-demand test disturbed");
endmodule

// ### verilog/bgm_defs.svh
// Purpose: Constants of the bandgap monitor and comparator self-test block
// Assumes: 100 MHz system clock, 8-bit register port
// Notes:   Offsets, field positions, reset values and timing counts
`ifndef BGM_DEFS_SVH
`define BGM_DEFS_SVH

// ----------------------------------------------------------------------
// Timing
// ----------------------------------------------------------------------
// Clock period in ns
`define BGM_CLK_NS 10
// Longest monitor blanking during a self-test, in us
`define BGM_BLANK_MAX_US 200
// Longest blanking in cycles, rounded down
`define BGM_BLANK_MAX_CYC ((`BGM_BLANK_MAX_US * 1000) / `BGM_CLK_NS)
// Settle time of each stimulus phase, in us
`define BGM_SETTLE_US 40
// Settle time in cycles, rounded up
`define BGM_SETTLE_CYC \
	((`BGM_SETTLE_US * 1000 + `BGM_CLK_NS - 1) / `BGM_CLK_NS)

// ----------------------------------------------------------------------
// Bandgap compare and rails
// ----------------------------------------------------------------------
// Percent difference at which the bandgaps count as drifted
`define BGM_BG_TRIP_PCT 8'h04
// Rail counts and comparator vector layout
`define BGM_N_BUCK 7
`define BGM_N_LIN 4
`define BGM_N_CMP 22
`define BGM_BUCK_OV_LSB 0
`define BGM_LIN_OV_LSB 7
`define BGM_BUCK_UV_LSB 11
`define BGM_LIN_UV_LSB 18

// ----------------------------------------------------------------------
// Register offsets, bit positions, reset values
// ----------------------------------------------------------------------
`define BGM_OFF_STATUS 8'h00
`define BGM_OFF_IRQ 8'h01
`define BGM_OFF_MASK 8'h02
`define BGM_OFF_CTRL 8'h03
`define BGM_OFF_BUCK_OV 8'h04
`define BGM_OFF_LIN_OV 8'h05
`define BGM_OFF_BUCK_UV 8'h06
`define BGM_OFF_LIN_UV 8'h07
`define BGM_STAT_BG_BIT 0
`define BGM_STAT_BUSY_BIT 1
`define BGM_STAT_ON_BIT 2
`define BGM_STAT_BLK_BIT 3
`define BGM_CTRL_TRIG_BIT 0
`define BGM_CTRL_BYP_BIT 1
`define BGM_CTRL_SEC_BIT 2
`define BGM_CTRL_RST 8'h00
`define BGM_MASK_RST 1'b0
`define BGM_RDATA_RST 8'h00

`endif

// ### verilog/bgm_pkg.sv
// Purpose: Types of the bandgap monitor and self-test block
// Assumes: bgm_defs.svh holds the numbers
// Notes:   Types only
package bgm_pkg;
`include "bgm_defs.svh"
	// Register data and address
	typedef logic [7:0] bgm_byte_t;
	// Measured bandgap difference in percent
	typedef logic [7:0] bgm_pct_t;
	// All comparators, buck OV, linear OV, buck UV, linear UV
	typedef logic [`BGM_N_CMP-1:0] bgm_cmp_vec_t;
	// Power control states
	typedef enum logic [1:0] {PWR_OFF, PWR_TEST, PWR_ON, PWR_BLOCKED}
		bgm_pwr_state_t;
	// Self-test engine states
	typedef enum logic [1:0] {ST_IDLE, ST_LOW, ST_HIGH} bgm_st_state_t;
endpackage

// ### verilog/bgm_st_if.sv
// Purpose: Link between control logic and the comparator self-test engine
// Assumes: One clock domain
// Notes:   start is a one-cycle request, done a one-cycle answer
`timescale 1ns/100ps
interface bgm_st_if;
	import bgm_pkg::*;
	// Request a self-test run
	logic start;
	// Engine running or reporting
	logic busy;
	// Run finished, fail vector valid
	logic done;
	// One bit per comparator that did not toggle
	bgm_cmp_vec_t fail;
	modport ctl (output start, input busy, input done, input fail);
	modport eng (input start, output busy, output done, output fail);
endinterface

// ### verilog/bgm_bg_mon.sv
// Purpose: Compares regulator and monitor bandgaps
// Assumes: Difference arrives as a percentage, synchronous to clk_sys
// Notes:   Gives the live drift level and a pulse on its rising edge
`timescale 1ns/100ps
module bgm_bg_mon (
	input wire logic clk_sys,
	input wire logic rst,
	input wire bgm_pkg::bgm_pct_t bg_diff_pct,
	output logic bg_fault,
	output logic bg_fault_rise
);
	import bgm_pkg::*;

	// Drift level and edge
	logic next_fault;
	logic next_rise;

	// Drift test on a measured difference
	function automatic logic bgm_is_drift(input bgm_pct_t d);
		return d >= `BGM_BG_TRIP_PCT;
	endfunction

	// ------------------------------------------------------------------
	// Compare
	// ------------------------------------------------------------------
	// Next drift level and rising edge
	always_comb begin
		// RQ1 drift threshold compare
		next_fault = bgm_is_drift(bg_diff_pct);
		next_rise = next_fault & ~bg_fault;
	end

	// Register level and pulse
	always_ff @(posedge clk_sys) begin
		if (rst) begin
			bg_fault <= 1'b0;
			bg_fault_rise <= 1'b0;
		end else begin
			bg_fault <= next_fault;
			bg_fault_rise <= next_rise;
		end
	end

	// Drift flagged one cycle after the difference reaches the trip
	drift_trip_a: assert property (@(posedge clk_sys) disable iff (rst) // RQ1
		(bg_diff_pct >= `BGM_BG_TRIP_PCT) |=> bg_fault)
		else $error("bandgap drift not flagged");
endmodule

// ### verilog/bgm_selftest.sv
// Purpose: Checks that every OV and UV comparator can toggle
// Assumes: Stimulus high trips all comparators, low releases them
// Notes:   Two settle phases; blanking lasts the whole run
`timescale 1ns/100ps
module bgm_selftest #(
	parameter int SETTLE_CYC = `BGM_SETTLE_CYC
) (
	input wire logic clk_sys,
	input wire logic rst,
	bgm_st_if.eng st,
	input wire bgm_pkg::bgm_cmp_vec_t cmp_out,
	output logic cmp_test_stim
);
	import bgm_pkg::*;

	// Last count of a phase
	localparam logic [15:0] SETTLE_LAST = 16'(SETTLE_CYC - 1);

	bgm_st_state_t state, next_state; // Engine state
	logic [15:0] cnt, next_cnt; // Phase counter
	bgm_cmp_vec_t low_ok, next_low_ok; // Released reading seen low
	bgm_cmp_vec_t fail, next_fail; // Result of the run
	logic done, next_done; // Result pulse
	logic next_stim; // Stimulus for next cycle
	logic phase_end; // Phase settled

	assign phase_end = (cnt == SETTLE_LAST);
	assign st.busy = (state != ST_IDLE) | done;
	assign st.done = done;
	assign st.fail = fail;

	// ------------------------------------------------------------------
	// Sequencer
	// ------------------------------------------------------------------
	// Release phase, then trip phase, then report
	always_comb begin
		next_state = state;
		next_cnt = cnt + 16'h0001;
		next_done = 1'b0;
		case (state)
			ST_IDLE: begin
				next_cnt = 16'h0000;
				// RQ8 start comparator test
				if (st.start) begin
					next_state = ST_LOW;
				end
			end
			ST_LOW: begin
				if (phase_end) begin
					next_state = ST_HIGH;
					next_cnt = 16'h0000;
				end
			end
			ST_HIGH: begin
				if (phase_end) begin
					next_state = ST_IDLE;
					next_done = 1'b1;
				end
			end
			default: next_state = ST_IDLE;
		endcase
		next_stim = (next_state == ST_HIGH);
	end

	// Per comparator capture: must read low released, high tripped
	genvar i;
	generate
		for (i = 0; i < `BGM_N_CMP; i++) begin : g_cmp
			// RQ9 per comparator fail bit
			assign next_low_ok[i] = (state == ST_LOW && phase_end) ?
				~cmp_out[i] : (state == ST_IDLE ? 1'b0 : low_ok[i]);
			assign next_fail[i] = (state == ST_HIGH && phase_end) ?
				~(low_ok[i] & cmp_out[i]) : fail[i];
		end
	endgenerate

	// Register the engine
	always_ff @(posedge clk_sys) begin
		if (rst) begin
			state <= ST_IDLE;
			cnt <= 16'h0000;
			low_ok <= '0;
			fail <= '0;
			done <= 1'b0;
			cmp_test_stim <= 1'b0;
		end else begin
			state <= next_state;
			cnt <= next_cnt;
			low_ok <= next_low_ok;
			fail <= next_fail;
			done <= next_done;
			cmp_test_stim <= next_stim;
		end
	end

	// Release phase comes first, with stimulus low; needs SETTLE_CYC >= 4
	sequence st_begin_s;
		st.start && state == ST_IDLE;
	endsequence
	release_first_a: assert property (@(posedge clk_sys) disable iff (rst)
		st_begin_s |=> (!cmp_test_stim && st.busy)[*4]) // RQ8
		else $error("self-test did not begin with released stimulus");
endmodule

// ### verification/bgm_cmp_model.sv
// Purpose: Model of the OV/UV comparator bank behind the self-test
// Assumes: Stimulus high trips every healthy comparator
// Notes:   Bits set in stuck never trip, so they fail to toggle
`timescale 1ns/100ps
module bgm_cmp_model (
	input wire logic clk_sys,
	input wire logic cmp_test_stim,
	input wire bgm_pkg::bgm_cmp_vec_t stuck,
	output bgm_pkg::bgm_cmp_vec_t cmp_out
);
	import bgm_pkg::*;
	// Comparators answer one cycle after the stimulus moves
	always_ff @(posedge clk_sys) begin
		cmp_out <= cmp_test_stim ? ~stuck : '0;
	end
endmodule

// ### verification/bgm_top_tb.sv
// Purpose: Self-checking bench of the bandgap monitor and self-test
// Assumes: Short settle count so a run lasts a few cycles
// Notes:   Stuck comparator masks come from the bench LFSR
`timescale 1ns/100ps
`include "bgm_defs.svh"
module bgm_top_tb;
	import bgm_pkg::*;
	localparam int SC = 4;
	localparam int BM = 20;
	logic clk_sys = 1'b0;
	logic rst = 1'b1;
	bgm_byte_t addr = 8'h00;
	bgm_byte_t wdata = 8'h00;
	bgm_byte_t rdata;
	bgm_pct_t pct = 8'h00;
	logic wr_s = 1'b0;
	logic rd_s = 1'b0;
	logic sec = 1'b0;
	logic pu = 1'b0;
	logic pd = 1'b0;
	bgm_cmp_vec_t bad = '0;
	bgm_cmp_vec_t cmp_out;
	logic stim, monitor_blank, reg_power_en, pwrup_blocked, bandgap_irq;
	int n_mismatch = 0;
	int checked = 0;
	int bcnt = 0;
	int blen = 0;
	int n;
	logic [31:0] lf = 32'h0000_27a8;

	always #5 clk_sys = ~clk_sys;

	// Length of the last blanking window, in cycles
	always @(posedge clk_sys) begin
		if (monitor_blank === 1'b1) begin
			bcnt <= bcnt + 1;
		end else if (bcnt != 0) begin
			blen <= bcnt;
			bcnt <= 0;
		end
	end

	bgm_top #(.BLANK_MAX_CYC(BM), .SETTLE_CYC(SC)) i_dut (
		.clk_sys(clk_sys), .rst(rst), .reg_addr(addr),
		.reg_wdata(wdata), .reg_wr(wr_s), .reg_rd(rd_s),
		.reg_secure(sec), .reg_rdata(rdata), .bg_diff_pct(pct),
		.pwrup_req(pu), .pwrdn_req(pd), .cmp_out(cmp_out),
		.cmp_test_stim(stim), .monitor_blank(monitor_blank),
		.reg_power_en(reg_power_en), .pwrup_blocked(pwrup_blocked),
		.bandgap_irq(bandgap_irq)
	);

	bgm_cmp_model i_cmp (
		.clk_sys(clk_sys), .cmp_test_stim(stim), .stuck(bad),
		.cmp_out(cmp_out)
	);

	// ----------------------------------------------------------------
	// Helpers
	// ----------------------------------------------------------------
	function automatic logic [31:0] lfsr(input logic [31:0] x);
		return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
	endfunction

	// Expected warn register r for a stuck mask
	function automatic bgm_byte_t ew(input bgm_cmp_vec_t m, input int r);
		case (r)
			0: return {1'b0, m[6:0]};
			1: return {4'h0, m[10:7]};
			2: return {1'b0, m[17:11]};
			default: return {4'h0, m[21:18]};
		endcase
	endfunction

	function automatic logic sig(input int s);
		case (s)
			0: return reg_power_en;
			1: return monitor_blank;
			default: return pwrup_blocked;
		endcase
	endfunction

	task automatic wrap_up();
		$display("checks %0d mismatches %0d", checked, n_mismatch);
		if (n_mismatch == 0 && checked > 0) begin
			$display("Result: passed");
		end else begin
			$display("Result: failed");
		end
		$finish;
	endtask

	task automatic chk(input string nm, input logic [31:0] seen,
		input logic [31:0] exp);
		checked++;
		if (seen !== exp) begin
			n_mismatch++;
			$display("[ERR] %s expected %h seen %h", nm, exp, seen);
		end
	endtask

	// Register write, one strobe cycle
	task automatic wr(input bgm_byte_t a, input bgm_byte_t d,
		input logic s);
		@(posedge clk_sys);
		addr <= a;
		wdata <= d;
		sec <= s;
		wr_s <= 1'b1;
		@(posedge clk_sys);
		wr_s <= 1'b0;
		sec <= 1'b0;
	endtask

	// Register read, data stands in the following cycle only
	task automatic rchk(input bgm_byte_t a, input bgm_byte_t e,
		input string nm);
		@(posedge clk_sys);
		addr <= a;
		rd_s <= 1'b1;
		@(posedge clk_sys);
		rd_s <= 1'b0;
		#1;
		chk(nm, rdata, e);
	endtask

	// Bounded wait for an output level
	task automatic wt(input int s, input logic v, output int c);
		c = 0;
		#1;
		while (sig(s) !== v) begin
			@(posedge clk_sys);
			#1;
			c++;
			if (c > 200) begin
				n_mismatch++;
				$display("[ERR] wait %0d expected %b seen timeout", s, v);
				wrap_up();
			end
		end
	endtask

	task automatic cw(input bgm_cmp_vec_t m);
		for (int r = 0; r < 4; r++) begin
			rchk(8'h04 + r[7:0], ew(m, r), "warn");
		end
	endtask

	// ----------------------------------------------------------------
	// Main sequence
	// ----------------------------------------------------------------
	initial begin
		repeat (8) @(posedge clk_sys);
		rst <= 1'b0;
		for (int a = 0; a < 4; a++) begin
			rchk(a[7:0], 8'h00, "reset");
		end
		rchk(8'h3f, 8'h00, "unmapped");
		// Power-up with random stuck comparators
		lf = lfsr(lf);
		bad <= lf[21:0];
		pu <= 1'b1;
		wt(0, 1'b1, n);
		chk("blocked", pwrup_blocked, 1'b0);
		cw(bad);
		rchk(8'h00, 8'h04, "status on");
		// On-demand run, second trigger while busy
		lf = lfsr(lf);
		bad <= lf[21:0] | 22'h00_0001;
		wr(8'h03, 8'h01, 1'b0);
		rchk(8'h03, 8'h01, "trig busy");
		wr(8'h03, 8'h01, 1'b0);
		wt(1, 1'b0, n);
		repeat (4) @(posedge clk_sys);
		#1;
		chk("blank len", blen, 2 * SC + 1);
		chk("blank max", blen <= BM, 1'b1);
		chk("no rerun", monitor_blank, 1'b0);
		rchk(8'h03, 8'h00, "trig clear");
		cw(bad);
		chk("still on", reg_power_en, 1'b1);
		// Secure mode guards warn and trigger
		wr(8'h03, 8'h04, 1'b0);
		wr(8'h04, 8'hff, 1'b0);
		rchk(8'h04, ew(bad, 0), "plain clr");
		wr(8'h03, 8'h05, 1'b0);
		repeat (3) @(posedge clk_sys);
		#1;
		chk("plain trig", monitor_blank, 1'b0);
		wr(8'h04, 8'hff, 1'b1);
		rchk(8'h04, 8'h00, "secure clr");
		// Secure trigger write runs a test that refills the warn bits
		wr(8'h03, 8'h05, 1'b1);
		wt(1, 1'b1, n);
		wt(1, 1'b0, n);
		cw(bad);
		// Drift at top of window with bypass: flag only
		wr(8'h03, 8'h06, 1'b1);
		pct <= 8'h0c;
		repeat (4) @(posedge clk_sys);
		rchk(8'h00, 8'h05, "drift on");
		chk("irq", bandgap_irq, 1'b1);
		rchk(8'h01, 8'h01, "flag");
		pct <= 8'h03;
		wr(8'h01, 8'h01, 1'b0);
		rchk(8'h01, 8'h00, "flag clr");
		rchk(8'h00, 8'h04, "drift off");
		// Power-down request, then power-up again
		pd <= 1'b1;
		wt(0, 1'b0, n);
		pd <= 1'b0;
		wt(0, 1'b1, n);
		chk("re-up", pwrup_blocked, 1'b0);
		// Drift at bottom of window, no bypass: shutdown
		wr(8'h03, 8'h04, 1'b1);
		pct <= 8'h04;
		wt(0, 1'b0, n);
		chk("off delay", n <= 3, 1'b1);
		wt(2, 1'b1, n);
		// Power-up with drift and bypass set stays blocked
		wr(8'h03, 8'h06, 1'b1);
		pu <= 1'b0;
		wt(2, 1'b0, n);
		pu <= 1'b1;
		wt(2, 1'b1, n);
		chk("byp block", reg_power_en, 1'b0);
		// Masked source does not raise the flag
		pu <= 1'b0;
		pct <= 8'h00;
		wr(8'h01, 8'h01, 1'b0);
		wr(8'h02, 8'h01, 1'b0);
		pct <= 8'h08;
		repeat (4) @(posedge clk_sys);
		#1;
		chk("masked", bandgap_irq, 1'b0);
		// Drift arising during the power-up test, bypass still set
		pct <= 8'h00;
		repeat (2) @(posedge clk_sys);
		pu <= 1'b1;
		wt(1, 1'b1, n);
		pct <= 8'h08;
		wt(2, 1'b1, n);
		chk("test drift", reg_power_en, 1'b0);
		wrap_up();
	end
endmodule
